//--- src/manchester_serial_codec_consts.vh
// timing, reset and sizing constants for the manchester serial codec
`ifndef MANCHESTER_SERIAL_CODEC_CONSTS_VH
`define MANCHESTER_SERIAL_CODEC_CONSTS_VH

`define CLK_PERIOD_NS    10
`define BIT_TIME_NS      100
`define BIT_CYC          (`BIT_TIME_NS / `CLK_PERIOD_NS)
`define HALF_CYC         (`BIT_CYC / 2)
`define QTR_CYC          (`BIT_CYC / 4)

`define CAR_GLITCH_NS    20
`define CAR_GLITCH_CYC   ((`CAR_GLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define COL_GLITCH_NS    10
`define COL_GLITCH_CYC   ((`COL_GLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define CARR_OFF_NS      155
`define CARR_OFF_CYC     (`CARR_OFF_NS / `CLK_PERIOD_NS)

`define PREAMBLE_GAP_CYC (2 * `BIT_CYC)
`define PREAMBLE_TOL_CYC `QTR_CYC
`define RCLK_RISE_PH     (`HALF_CYC + `QTR_CYC)

`define FIFO_WIDTH       1
`define FIFO_DEPTH       4
`define FIFO_AW          2

`define RST_RX_DATA      1'b1
`define RST_RX_CLOCK     1'b0
`define RST_TX_POS       1'b1
`define RST_TX_NEG       1'b0
`define RST_BIT_CLOCK    1'b0
`define RST_IDLE_OE_N    1'b1

`endif

//--- src/manchester_serial_codec.v
// manchester encoder/decoder with carrier and collision detection
// Summary of operation
// - collision flag high while filtered collision input active, low otherwise
// - reject carrier pulses under 20 ns and collision pulses under 10 ns
// - recovered data held high while receive line idle in normal mode
// - recovered data changes only just after recovered clock rising edge, apart from its return to high at idle
// - recovered data active from clock start until receive valid drops
// - receive valid low at idle, high on carrier on, low on carrier off
// - recovered clock held low while receive line idle in normal mode
// - recovered clock starts quarter bit after second preamble fall, runs past end
// - clock and data acquired within four bit times of preamble start
// - one: positive output low first half; zero: positive output high first half
// - data and enable sampled on bit clock; encode only while enable high
// - bit rate clock output symmetric, at data rate
// - bit rate clock is oscillator input divided by two
// - idle select low: idle pair with positive output high
// - idle select high: idle pair at zero differential, outputs equal
// - idle select pin pulled low during transmission, released afterwards
// - collision inputs never touch receive or transmit data paths
// - test low: data enabled, clock enabled except held high in acquisition
// - clock locks only after valid 1010 preamble following carrier detect
// - receive valid drops together with a recovered clock rising edge once locked, at once when carrier ends in acquisition
// - internal carrier goes inactive about 155 ns after last rising line edge or filtered carrier input drop, whichever is later
`timescale 1ns/100ps
`include "manchester_serial_codec_consts.vh"

module rx_bit_fifo #(
  parameter WIDTH = 1,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             clock,
  input  wire             sys_rst,
  input  wire             flush,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      count_r;
  wire            do_push;
  wire            do_pop;

  assign in_ready  = (count_r != DEPTH[AW:0]);
  assign out_valid = (count_r != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr_r];
  assign do_push   = in_valid & in_ready;
  assign do_pop    = out_valid & out_ready;

  always @(posedge clock) begin
    if (do_push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end else if (flush) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (do_push & ~do_pop) begin
        count_r <= count_r + 1'b1;
      end else if (do_pop & ~do_push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

module manchester_serial_codec (
  input  wire clock,
  input  wire sys_rst,
  input  wire osc_in,
  input  wire tx_data_in,
  input  wire transmit_enable_in,
  output wire bit_rate_clock_out,
  output wire tx_pos_out,
  output wire tx_neg_out,
  input  wire idle_select_in,
  output wire idle_select_out,
  output wire idle_select_oe_n,
  input  wire rx_line_in,
  input  wire carrier_in,
  input  wire test_n,
  output wire receive_valid,
  output wire rx_clock_out,
  output wire rx_data_out,
  output wire rx_overflow,
  input  wire collision_in,
  output wire collision_flag
);
  localparam [4:0] ST_IDLE  = 5'h01;
  localparam [4:0] ST_ACQ1  = 5'h02;
  localparam [4:0] ST_ACQ2  = 5'h04;
  localparam [4:0] ST_LOCK  = 5'h08;
  localparam [4:0] ST_DRAIN = 5'h10;

  // integer forms first, then cut to the counter widths on purpose
  localparam integer PH_LAST_I  = `BIT_CYC - 1;
  localparam integer PH_QTR_I   = `QTR_CYC;
  localparam integer PH_HALF_I  = `HALF_CYC;
  localparam integer PH_RISE_I  = `RCLK_RISE_PH;
  localparam integer GAP_MIN_I  = `PREAMBLE_GAP_CYC - `PREAMBLE_TOL_CYC;
  localparam integer GAP_MAX_I  = `PREAMBLE_GAP_CYC + `PREAMBLE_TOL_CYC;
  localparam integer CARR_END_I = `CARR_OFF_CYC - 1;
  localparam integer CAR_LEN_I  = `CAR_GLITCH_CYC;
  localparam integer COL_LEN_I  = `COL_GLITCH_CYC;
  localparam [3:0] PH_LAST  = PH_LAST_I[3:0];
  localparam [3:0] PH_QTR   = PH_QTR_I[3:0];
  localparam [3:0] PH_HALF  = PH_HALF_I[3:0];
  localparam [3:0] PH_RISE  = PH_RISE_I[3:0];
  localparam [4:0] GAP_MIN  = GAP_MIN_I[4:0];
  localparam [4:0] GAP_MAX  = GAP_MAX_I[4:0];
  localparam [4:0] CARR_END = CARR_END_I[4:0];

  // glitch length per filter channel: 0 carrier, 1 collision
  function [1:0] filt_len;
    input integer chan;
    begin
      if (chan == 0) begin
        filt_len = CAR_LEN_I[1:0];
      end else begin
        filt_len = COL_LEN_I[1:0];
      end
    end
  endfunction

  wire [1:0] filt_raw;
  wire [1:0] filt_out;
  assign filt_raw = {collision_in, carrier_in};

  // a level must persist beyond the glitch length before it passes
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_filt
      reg [1:0] cnt_r;
      reg       lvl_r;
      always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          cnt_r <= 2'h0;
          lvl_r <= 1'b0;
        end else if (filt_raw[gi] == lvl_r) begin
          cnt_r <= 2'h0;
        end else if (cnt_r == filt_len(gi)) begin
          lvl_r <= filt_raw[gi];
          cnt_r <= 2'h0;
        end else begin
          cnt_r <= cnt_r + 2'h1;
        end
      end
      assign filt_out[gi] = lvl_r;
    end
  endgenerate

  // collision path is isolated: only collision_flag_r reads filt_out[1]
  reg collision_flag_r;
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      collision_flag_r <= 1'b0;
    end else begin
      collision_flag_r <= filt_out[1];
    end
  end

  // transmit side, timed off oscillator rising edges
  reg osc_prev_r;
  reg bit_clk_r;
  reg tx_act_r;
  reg tx_bit_r;
  reg tx_pos_r;
  reg tx_neg_r;
  reg idle_oe_n_r;
  reg idle_drv_r;
  wire osc_rise;
  assign osc_rise = osc_in & ~osc_prev_r;

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      osc_prev_r  <= 1'b0;
      bit_clk_r   <= `RST_BIT_CLOCK;
      tx_act_r    <= 1'b0;
      tx_bit_r    <= 1'b0;
      tx_pos_r    <= `RST_TX_POS;
      tx_neg_r    <= `RST_TX_NEG;
      idle_oe_n_r <= `RST_IDLE_OE_N;
      idle_drv_r  <= 1'b0;
    end else begin
      osc_prev_r <= osc_in;
      idle_drv_r <= 1'b0;
      if (osc_rise) begin
        bit_clk_r <= ~bit_clk_r;
        if (~bit_clk_r) begin
          tx_act_r    <= transmit_enable_in;
          tx_bit_r    <= tx_data_in;
          idle_oe_n_r <= ~transmit_enable_in;
          if (transmit_enable_in) begin
            tx_pos_r <= ~tx_data_in;
            tx_neg_r <= tx_data_in;
          end else begin
            // pin sensed low while our pull-down decays, giving a soft idle
            tx_pos_r <= ~idle_select_in;
            tx_neg_r <= 1'b0;
          end
        end else if (tx_act_r) begin
          tx_pos_r <= tx_bit_r;
          tx_neg_r <= ~tx_bit_r;
        end
      end
    end
  end

  // receive side
  reg       rx_prev_r;
  reg       icarr_r;
  reg [4:0] carr_cnt_r;
  reg [4:0] st_r;
  reg [4:0] st_nxt;
  reg [3:0] ph_r;
  reg [3:0] ph_nxt;
  reg [4:0] acq_r;
  reg [4:0] acq_nxt;
  reg       rv_r;
  reg       rv_nxt;
  reg       rclk_r;
  reg       rclk_nxt;
  reg       rxd_r;
  reg       rxd_nxt;
  reg       ovf_r;
  reg       ovf_nxt;
  reg       push;
  reg       pop;
  reg       flush;
  reg       phase_hi;
  wire      rx_fall;
  wire      rx_rise;
  wire      fifo_in_ready;
  wire      fifo_out_valid;
  wire      fifo_out_data;

  assign rx_fall = rx_prev_r & ~rx_line_in;
  assign rx_rise = ~rx_prev_r & rx_line_in;

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rx_prev_r  <= 1'b1;
      icarr_r    <= 1'b0;
      carr_cnt_r <= 5'h00;
    end else begin
      rx_prev_r <= rx_line_in;
      if (filt_out[0] | rx_rise) begin
        carr_cnt_r <= 5'h00;
      end else if (icarr_r) begin
        carr_cnt_r <= carr_cnt_r + 5'h01;
      end
      if (filt_out[0]) begin
        icarr_r <= 1'b1;
      end else if (icarr_r & ~rx_rise & (carr_cnt_r == CARR_END)) begin
        icarr_r <= 1'b0;
      end
    end
  end

  always @* begin
    st_nxt  = st_r;
    ph_nxt  = (ph_r == PH_LAST) ? 4'h0 : ph_r + 4'h1;
    acq_nxt = (acq_r == 5'h1f) ? acq_r : acq_r + 5'h01;
    rv_nxt  = rv_r;
    rxd_nxt = rxd_r;
    ovf_nxt = ovf_r;
    push    = 1'b0;
    pop     = 1'b0;
    flush   = 1'b0;
    case (st_r)
      ST_IDLE: begin
        if (icarr_r) begin
          st_nxt  = ST_ACQ1;
          rv_nxt  = 1'b1;
          ovf_nxt = 1'b0;
        end
      end
      ST_ACQ1: begin
        if (~icarr_r) begin
          st_nxt = ST_IDLE;
          rv_nxt = 1'b0;
        end else if (rx_fall) begin
          st_nxt  = ST_ACQ2;
          acq_nxt = 5'h00;
        end
      end
      ST_ACQ2: begin
        if (~icarr_r) begin
          st_nxt = ST_IDLE;
          rv_nxt = 1'b0;
        end else if (rx_fall) begin
          if ((acq_r >= GAP_MIN) && (acq_r <= GAP_MAX)) begin
            st_nxt = ST_LOCK;
            ph_nxt = PH_HALF + 4'h1;
          end else begin
            acq_nxt = 5'h00;
          end
        end else if (acq_r > GAP_MAX) begin
          st_nxt = ST_ACQ1;
        end
      end
      ST_LOCK: begin
        // realign on mid-cell edges only; boundary edges fall outside
        if ((rx_line_in != rx_prev_r) && (ph_r >= PH_HALF - PH_QTR) &&
            (ph_r <= PH_HALF + PH_QTR)) begin
          ph_nxt = PH_HALF + 4'h1;
        end
        if (ph_r == PH_QTR) begin
          push = 1'b1;
          if (~fifo_in_ready) begin
            ovf_nxt = 1'b1;
          end
        end
        if ((ph_r == PH_RISE) && fifo_out_valid) begin
          pop     = 1'b1;
          rxd_nxt = fifo_out_data;
        end
        if (~icarr_r && (ph_nxt == PH_RISE)) begin
          st_nxt = ST_DRAIN;
          rv_nxt = 1'b0;
        end
      end
      ST_DRAIN: begin
        if (ph_nxt == PH_QTR) begin
          st_nxt = ST_IDLE;
          flush  = 1'b1;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
        rv_nxt = 1'b0;
        flush  = 1'b1;
      end
    endcase
    phase_hi = (ph_nxt >= PH_RISE) || (ph_nxt < PH_QTR);
    case (st_nxt)
      ST_LOCK, ST_DRAIN: begin
        rclk_nxt = phase_hi;
      end
      ST_ACQ1, ST_ACQ2: begin
        rclk_nxt = ~test_n;
      end
      default: begin
        rclk_nxt = ~test_n & phase_hi;
      end
    endcase
    if ((st_nxt == ST_IDLE) && (st_r != ST_LOCK)) begin
      if (test_n) begin
        rxd_nxt = 1'b1;
      end else if (ph_r == PH_RISE) begin
        rxd_nxt = ~rx_line_in;
      end
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_r   <= ST_IDLE;
      ph_r   <= 4'h0;
      acq_r  <= 5'h00;
      rv_r   <= 1'b0;
      rclk_r <= `RST_RX_CLOCK;
      rxd_r  <= `RST_RX_DATA;
      ovf_r  <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      ph_r   <= ph_nxt;
      acq_r  <= acq_nxt;
      rv_r   <= rv_nxt;
      rclk_r <= rclk_nxt;
      rxd_r  <= rxd_nxt;
      ovf_r  <= ovf_nxt;
    end
  end

  rx_bit_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_rx_fifo (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .flush     (flush),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (~rx_line_in),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data)
  );

  assign bit_rate_clock_out = bit_clk_r;
  assign tx_pos_out         = tx_pos_r;
  assign tx_neg_out         = tx_neg_r;
  assign idle_select_out    = idle_drv_r;
  assign idle_select_oe_n   = idle_oe_n_r;
  assign receive_valid      = rv_r;
  assign rx_clock_out       = rclk_r;
  assign rx_data_out        = rxd_r;
  assign rx_overflow        = ovf_r;
  assign collision_flag     = collision_flag_r;
endmodule

//--- dv/codec_monitor.sv
// port-level assertions for the manchester codec, bound to its top
`timescale 1ns/100ps
module codec_monitor (
  input wire clock,
  input wire sys_rst,
  input wire osc_in,
  input wire tx_data_in,
  input wire transmit_enable_in,
  input wire bit_rate_clock_out,
  input wire tx_pos_out,
  input wire tx_neg_out,
  input wire idle_select_in,
  input wire idle_select_oe_n,
  input wire rx_line_in,
  input wire carrier_in,
  input wire test_n,
  input wire receive_valid,
  input wire rx_clock_out,
  input wire rx_data_out,
  input wire collision_in,
  input wire collision_flag
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  // quiet line time; bound covers carrier hang plus one full recovered cell
  logic [5:0] quiet_r;
  always @(posedge clock or posedge sys_rst)
    if (sys_rst)
      quiet_r <= 6'h00;
    else if (carrier_in || $rose(rx_line_in))
      quiet_r <= 6'h00;
    else if (quiet_r != 6'h3f)
      quiet_r <= quiet_r + 6'h01;

  sequence first_half;
    tx_pos_out == !$past(tx_data_in) && tx_neg_out == $past(tx_data_in);
  endsequence
  sequence mid_swap;
    ##[1:6] ($fell(bit_rate_clock_out) && $changed(tx_pos_out) && tx_pos_out != tx_neg_out);
  endsequence

  chk_collision_high: assert property (collision_in [*4] |-> collision_flag)
    else $error("collision flag not raised");
  chk_collision_low: assert property (!collision_in [*4] |-> !collision_flag)
    else $error("collision flag not lowered");
  chk_collision_glitch: assert property (!collision_in [*4] ##1 collision_in ##1 !collision_in
    |-> !collision_flag [*3])
    else $error("collision glitch passed");
  chk_valid_on: assert property (carrier_in [*4] |-> ##[0:3] receive_valid)
    else $error("receive valid late");
  // test mode clock and data need one cycle to settle after leaving test
  chk_rx_idle: assert property (quiet_r > 6'h28 && test_n && $past(test_n)
    |-> !receive_valid && !rx_clock_out && rx_data_out)
    else $error("receive side not idle");
  chk_valid_drop: assert property ($fell(receive_valid) |-> $rose(rx_clock_out))
    else $error("valid drop off clock edge");
  chk_data_sync: assert property (test_n && $past(receive_valid) && $changed(rx_data_out)
    |-> $past(rx_clock_out) && !$past(rx_clock_out, 2))
    else $error("data moved off clock rise");
  chk_bitclk_div: assert property (!$past(sys_rst) && !$past(sys_rst, 2)
    |-> $changed(bit_rate_clock_out) == ($past(osc_in) && !$past(osc_in, 2)))
    else $error("bit clock not osc half");
  chk_tx_cell: assert property ($rose(bit_rate_clock_out) && $past(transmit_enable_in)
    |-> first_half ##0 !idle_select_oe_n ##0 mid_swap)
    else $error("bad manchester cell");
  chk_tx_idle: assert property ($rose(bit_rate_clock_out) && !$past(transmit_enable_in)
    |-> idle_select_oe_n && !tx_neg_out && tx_pos_out == !$past(idle_select_in))
    else $error("bad idle pair");
endmodule

bind manchester_serial_codec codec_monitor u_mon (
  .clock(clock), .sys_rst(sys_rst), .osc_in(osc_in), .tx_data_in(tx_data_in),
  .transmit_enable_in(transmit_enable_in), .bit_rate_clock_out(bit_rate_clock_out),
  .tx_pos_out(tx_pos_out), .tx_neg_out(tx_neg_out), .idle_select_in(idle_select_in),
  .idle_select_oe_n(idle_select_oe_n), .rx_line_in(rx_line_in), .carrier_in(carrier_in),
  .test_n(test_n), .receive_valid(receive_valid), .rx_clock_out(rx_clock_out),
  .rx_data_out(rx_data_out), .collision_in(collision_in), .collision_flag(collision_flag)
);

//--- dv/line_source.sv
// line-side source of manchester frames and carrier
`timescale 1ns/100ps
module line_source (
  input  logic        clock,
  input  logic        go,
  input  logic [63:0] frame,
  input  int          len,
  output logic        rx_line_in,
  output logic        carrier_in
);
  initial begin
    rx_line_in = 1'b1;
    carrier_in = 1'b0;
    forever begin
      @(posedge clock);
      if (go) begin
        #1 carrier_in = 1'b1;
        // zero length gives a short squelch burst only
        if (len == 0) begin
          repeat (2) @(posedge clock);
          #1;
        end
        for (int i = 0; i < len; i++) begin
          rx_line_in = ~frame[i];
          repeat (5) @(posedge clock);
          #1 rx_line_in = frame[i];
          repeat (5) @(posedge clock);
          #1;
        end
        carrier_in = 1'b0;
        // released pair: no pull, so show the inverse of the last level
        rx_line_in = ~rx_line_in;
      end
    end
  end
endmodule

//--- dv/tb.sv
// self-checking bench for the manchester serial codec
`timescale 1ns/100ps
module tb;
  logic clock, sys_rst, osc_in, tx_data_in, transmit_enable_in, idle_rc, test_n;
  logic collision_in, go, noise;
  logic [63:0] frame;
  int len, osc_ph, rises, hi_cnt;
  int error_cnt = 0;
  int total_checks = 0;
  wire bit_rate_clock_out, tx_pos_out, tx_neg_out, idle_select_out, idle_select_oe_n;
  wire rx_line_in, carrier_in, receive_valid, rx_clock_out, rx_data_out, rx_overflow;
  wire collision_flag;
  wire idle_select_in = idle_select_oe_n ? idle_rc : idle_select_out;
  logic [2:0] txq[$];
  logic rxq[$];

  manchester_serial_codec u_dut (
    .clock(clock), .sys_rst(sys_rst), .osc_in(osc_in), .tx_data_in(tx_data_in),
    .transmit_enable_in(transmit_enable_in), .bit_rate_clock_out(bit_rate_clock_out),
    .tx_pos_out(tx_pos_out), .tx_neg_out(tx_neg_out), .idle_select_in(idle_select_in),
    .idle_select_out(idle_select_out), .idle_select_oe_n(idle_select_oe_n),
    .rx_line_in(rx_line_in), .carrier_in(carrier_in), .test_n(test_n),
    .receive_valid(receive_valid), .rx_clock_out(rx_clock_out), .rx_data_out(rx_data_out),
    .rx_overflow(rx_overflow), .collision_in(collision_in), .collision_flag(collision_flag)
  );
  line_source u_line (.clock(clock), .go(go), .frame(frame), .len(len),
    .rx_line_in(rx_line_in), .carrier_in(carrier_in));

  task automatic check(input string what, input logic [2:0] seen, input logic [2:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic tx_run(input logic idle_sel, input int n);
    logic en, d, prev_en;
    prev_en = 1'b0;
    @(posedge clock);
    #1 idle_rc = idle_sel;
    repeat (n) begin
      @(posedge bit_rate_clock_out);
      #1 en = ($urandom_range(0, 3) != 0);
      d = 1'($urandom);
      transmit_enable_in = en;
      tx_data_in = d;
      // idle pin reads low while the previous cell still pulls it
      txq.push_back(en ? {1'b0, ~d, d} : {1'b1, prev_en | ~idle_sel, 1'b0});
      prev_en = en;
    end
    @(posedge bit_rate_clock_out);
    #1 transmit_enable_in = 1'b0;
    repeat (2) @(posedge bit_rate_clock_out);
  endtask

  task automatic rx_frame(input logic [63:0] f, input int n);
    int cnt;
    cnt = 0;
    rises = 0;
    frame = f;
    len = n;
    // decoding starts at the fifth cell, after the two locking falls
    for (int i = 4; i < n; i++) rxq.push_back(f[i]);
    @(posedge clock);
    #1 go = 1'b1;
    @(posedge clock);
    #1 go = 1'b0;
    while (rx_clock_out !== 1'b1 && cnt < 60) begin
      @(posedge clock);
      #1 cnt++;
    end
    check("clock start", cnt >= 37 && cnt <= 40, 1'b1);
    repeat (n * 10 + 60) @(posedge clock);
    #1 check("bits left", rxq.size() == 0, 1'b1);
    check("overflow", rx_overflow, 1'b0);
    check("rx idle", {receive_valid, rx_clock_out, rx_data_out}, 3'b001);
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial forever begin
    @(posedge clock);
    #1 osc_ph = (osc_ph + 1) % 5;
    osc_in = (osc_ph < 2);
    if (noise)
      collision_in = 1'($urandom);
  end

  initial forever begin
    @(posedge bit_rate_clock_out);
    #0.5;
    if (txq.size() > 0) begin
      check("tx pair", {idle_select_oe_n, tx_pos_out, tx_neg_out}, txq.pop_front());
      check("idle pull", idle_select_out, 1'b0);
    end
  end

  initial forever begin
    @(posedge rx_clock_out);
    @(posedge clock);
    #1 rises++;
    if (rises > 1 && rxq.size() > 0)
      check("rx data", rx_data_out, rxq.pop_front());
  end

  initial begin
    #200000;
    error_cnt++;
    close_out();
  end

  initial begin
    sys_rst = 1'b1;
    osc_in = 1'b0;
    osc_ph = 0;
    tx_data_in = 1'b0;
    transmit_enable_in = 1'b0;
    idle_rc = 1'b0;
    test_n = 1'b1;
    collision_in = 1'b0;
    go = 1'b0;
    noise = 1'b0;
    frame = 64'h0;
    len = 0;
    void'($urandom(32'ha6f51f55));
    repeat (8) @(posedge clock);
    #1 sys_rst = 1'b0;
    tx_run(1'b0, 24);
    tx_run(1'b1, 24);
    @(posedge clock);
    #1 go = 1'b1;
    @(posedge clock);
    #1 go = 1'b0;
    repeat (6) @(posedge clock);
    #1 check("valid after burst", receive_valid, 1'b0);
    collision_in = 1'b1;
    repeat (4) @(posedge clock);
    #1 check("collision flag", collision_flag, 1'b1);
    collision_in = 1'b0;
    for (int k = 0; k < 2; k++) begin
      noise = k[0];
      // low byte is the 1010 preamble, sent least significant bit first
      rx_frame({32'($urandom), 24'($urandom), 8'h55}, 40 + 24 * k);
    end
    noise = 1'b0;
    // test mode: recovered clock free-runs, data follows the inverted line
    test_n = 1'b0;
    hi_cnt = 0;
    repeat (2) @(posedge clock);
    repeat (10) begin
      @(posedge clock);
      #1 hi_cnt += rx_clock_out;
    end
    check("test clock duty", 3'(hi_cnt), 3'h5);
    check("test data", rx_data_out, !rx_line_in);
    test_n = 1'b1;
    repeat (3) @(posedge clock);
    #1 check("normal idle", {receive_valid, rx_clock_out, rx_data_out}, 3'b001);
    close_out();
  end
endmodule
